/* File: pkg/tcs_consts.svh */
// constants of the touch conversion sequencer: timing, offsets, fields
`ifndef TCS_CONSTS_SVH
`define TCS_CONSTS_SVH

// clock and oscillator timing
`define TCS_CLK_PERIOD_NS     5
`define TCS_OSC_PERIOD_NS     125
`define TCS_OSC_DIV           (`TCS_OSC_PERIOD_NS / `TCS_CLK_PERIOD_NS)
`define TCS_SNS_REF_NS        32000
`define TCS_SNS_REF_TICKS     (`TCS_SNS_REF_NS / `TCS_OSC_PERIOD_NS)

// conversion block terms
`define TCS_N1_UNITY          6
`define TCS_N1_DIVIDED        7
`define TCS_BLOCK_FIXED       12
`define TCS_BLOCK_TAIL        1
`define TCS_RES_EXTRA_BIT     1
`define TCS_AVG_NONE          4'h1
`define TCS_RATIO_UNITY       4'h1

// sequence tails in oscillator periods, and panel counts
`define TCS_XY_PVS0_EXTRA     4
`define TCS_XY_SNS_EXTRA      2
`define TCS_XYZ_FIXED         33
`define TCS_XYZ_PVS0_EXTRA    4
`define TCS_XYZ_SNS_EXTRA     3
`define TCS_HXY_FIXED         14
`define TCS_HXY_PVS0_EXTRA    2
`define TCS_HZ_FIXED          20
`define TCS_HZ_PVS0_EXTRA     2
`define TCS_XY_PANELS         2'h2
`define TCS_XYZ_PANELS        2'h3
`define TCS_HOST_PANELS       2'h1

// register word addresses
`define TCS_ADDR_CTRL         4'h0
`define TCS_ADDR_PANEL        4'h1
`define TCS_ADDR_CONV         4'h2
`define TCS_ADDR_STATUS       4'h3
`define TCS_ADDR_LAST         4'h4

// field positions
`define TCS_CTRL_GO           0
`define TCS_CTRL_OP_LSB       1
`define TCS_CTRL_AUTO         3
`define TCS_CTRL_PEN_LSB      4
`define TCS_PANEL_W           30
`define TCS_CONV_W            12
`define TCS_ST_BUSY           0
`define TCS_ST_TOUCH          1
`define TCS_ST_AUDIO          2
`define TCS_ST_COUNT_LSB      8

// reset values and pen modes
`define TCS_RST_PANEL         30'h0000_0000
`define TCS_RST_CONV          12'h1C1
`define TCS_PEN_SILENT        2'h1

`endif

/* File: pkg/tcs_pkg.sv */
// types of the touch conversion sequencer
package tcs_pkg;

	// sequencer phases, gray along idle-panel-conv-tail
	typedef enum logic [1:0] {
		TCS_IDLE  = 2'h0,
		TCS_PANEL = 2'h1,
		TCS_CONV  = 2'h3,
		TCS_TAIL  = 2'h2
	} tcs_state_type;

	// scan kinds
	typedef enum logic [1:0] {
		TCS_TOUCH_XY  = 2'h0,
		TCS_TOUCH_XYZ = 2'h1,
		TCS_HOST_XY   = 2'h2,
		TCS_HOST_Z    = 2'h3
	} tcs_op_type;

	// register port request
	typedef struct packed {
		logic [3:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} tcs_bus_req_type;

	// panel delays in oscillator ticks
	typedef struct packed {
		logic [9:0] panel_settle_time;
		logic [9:0] sense;
		logic [9:0] precharge;
	} tcs_panel_cfg_type;

	// converter setup
	typedef struct packed {
		logic [3:0] conv_ratio;
		logic [3:0] resolution_bits;
		logic [3:0] average_count;
	} tcs_conv_cfg_type;

endpackage : tcs_pkg

/* File: verilog/tcs_osc_divider.sv */
// oscillator tick divider: one-cycle enable per oscillator period
module tcs_osc_divider #(
	parameter int DIV = 25
) (
	// clock and reset
	input  wire logic clk_in,
	input  wire logic reset_in,
	// tick enable
	output logic      tick_out
);
	localparam int W = $clog2(DIV);

	logic [W-1:0] count;
	wire          wrap = (count == W'(DIV - 1));

	// free-running count, pulse on wrap
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			count    <= '0;
			tick_out <= 1'b0;
		end else begin
			count    <= wrap ? '0 : count + W'(1);
			tick_out <= wrap;
		end
	end
endmodule : tcs_osc_divider

/* File: verilog/tcs_tick_counter.sv */
// loadable down counter of oscillator ticks
module tcs_tick_counter #(
	parameter int W = 16
) (
	// clock and reset
	input  wire logic         clk_in,
	input  wire logic         reset_in,
	// control
	input  wire logic         load_in,
	input  wire logic [W-1:0] value_in,
	input  wire logic         tick_in,
	// state
	output logic [W-1:0]      remaining_out,
	output logic              zero_out
);
	// load beats tick so a phase never starts one tick short
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			remaining_out <= '0;
		end else if (load_in) begin
			remaining_out <= value_in;
		end else if (tick_in && !zero_out) begin
			remaining_out <= remaining_out - W'(1);
		end
	end

	assign zero_out = (remaining_out == '0);
endmodule : tcs_tick_counter

/* File: verilog/tcs_sequencer.sv */
// touch conversion sequencer: timed panel, conversion and tail phases
//
// How it works
// - a touch X/Y scan takes two panel intervals, two blocks, +4 if settle is zero, +2 if sense is not 32 us.
// - a block is average_count*((resolution_bits+1)*ratio+n1+12)+1 periods, n1 being 6 at unity ratio else 7.
// - a touch X/Y/Z1/Z2 scan takes three panel intervals, four blocks, 33 periods, +4 and +3 likewise.
// - a host X or Y takes the settle time, one block and 14 periods, +2 when settle is zero.
// - a host Z takes the settle time, two blocks and 20 periods, +2 when settle is zero.
// - the counts hold only with audio idle; audio stretches every block.
// - the first block after a new touch may run longer; later ones keep the counts.
// - in a continuous touch with pen mode other than 01, pen output is high for precharge plus sense.
// - the resolution part of a block grows with resolution_bits+1 converter clocks.
`include "tcs_consts.svh"
module tcs_sequencer #(
	parameter int AUDIO_EXTRA = 8,
	parameter int FIRST_EXTRA = 4,
	parameter int CNT_W       = 16
) (
	// clock and reset
	input  wire logic                     clk_in,
	input  wire logic                     reset_in,
	// register port
	input  wire tcs_pkg::tcs_bus_req_type bus_in,
	output logic [31:0]                   rd_data_out,
	// pins from outside
	input  wire logic                     touch_in,
	input  wire logic                     audio_active_in,
	// sequencer outputs
	output logic                          pen_data_avail_out,
	output logic                          busy_out,
	output logic                          done_out,
	output logic                          sample_strobe_out
);
	import tcs_pkg::*;

	// panel interval of one scan phase
	function automatic logic [CNT_W-1:0] panel_len_f(
		input tcs_op_type        op,
		input tcs_panel_cfg_type p
	);
		if (op[1]) begin
			return CNT_W'(p.panel_settle_time);
		end
		return CNT_W'(p.precharge) + CNT_W'(p.sense) +
			CNT_W'(p.panel_settle_time);
	endfunction : panel_len_f

	// fixed tail of each scan kind
	function automatic logic [CNT_W-1:0] tail_len_f(
		input tcs_op_type        op,
		input tcs_panel_cfg_type p
	);
		logic pvs0;
		logic sns_off;
		pvs0    = (p.panel_settle_time == '0);
		sns_off = (CNT_W'(p.sense) != CNT_W'(`TCS_SNS_REF_TICKS));
		case (op)
			TCS_TOUCH_XY: return CNT_W'(
				(pvs0 ? `TCS_XY_PVS0_EXTRA : 0) +
				(sns_off ? `TCS_XY_SNS_EXTRA : 0));
			TCS_TOUCH_XYZ: return CNT_W'(`TCS_XYZ_FIXED +
				(pvs0 ? `TCS_XYZ_PVS0_EXTRA : 0) +
				(sns_off ? `TCS_XYZ_SNS_EXTRA : 0));
			TCS_HOST_XY: return CNT_W'(`TCS_HXY_FIXED +
				(pvs0 ? `TCS_HXY_PVS0_EXTRA : 0));
			default: return CNT_W'(`TCS_HZ_FIXED +
				(pvs0 ? `TCS_HZ_PVS0_EXTRA : 0));
		endcase
	endfunction : tail_len_f

	// synchronisers and settings
	logic              touch_meta;
	logic              touch_sync;
	logic              touch_prev;
	logic              audio_meta;
	logic              audio_sync;
	tcs_op_type        op_cfg;
	logic              auto_en;
	logic [1:0]        pen_mode;
	tcs_panel_cfg_type panel_cfg;
	tcs_conv_cfg_type  conv_cfg;

	// sequencer state
	tcs_state_type     state;
	tcs_state_type     next_state;
	tcs_op_type        cur_op;
	logic [1:0]        panels_left;
	logic              conv_extra;
	logic              first_pending;
	logic [CNT_W-1:0]  dur_count;
	logic [CNT_W-1:0]  last_dur;
	logic [7:0]        scan_count;
	logic [31:0]       rd_mux;

	// counter hookup
	logic              osc_tick;
	logic              cnt_load;
	logic [CNT_W-1:0]  cnt_value;
	logic [CNT_W-1:0]  cnt_rem;
	logic              cnt_zero;

	tcs_osc_divider #(
		.DIV (`TCS_OSC_DIV)
	) u_div (
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.tick_out (osc_tick)
	);

	tcs_tick_counter #(
		.W (CNT_W)
	) u_cnt (
		.clk_in        (clk_in),
		.reset_in      (reset_in),
		.load_in       (cnt_load),
		.value_in      (cnt_value),
		.tick_in       (osc_tick),
		.remaining_out (cnt_rem),
		.zero_out      (cnt_zero)
	);

	// register decode
	wire wr_ctrl  = bus_in.wr && (bus_in.addr == `TCS_ADDR_CTRL);
	wire wr_panel = bus_in.wr && (bus_in.addr == `TCS_ADDR_PANEL);
	wire wr_conv  = bus_in.wr && (bus_in.addr == `TCS_ADDR_CONV);
	wire [1:0] wr_op = bus_in.wdata[`TCS_CTRL_OP_LSB +: 2];

	// start conditions: a host command wins over a touch restart
	wire host_go  = wr_ctrl && bus_in.wdata[`TCS_CTRL_GO] && wr_op[1];
	wire touch_go = auto_en && touch_sync && !op_cfg[1];
	wire start    = (state == TCS_IDLE) && (host_go || touch_go);
	wire tcs_op_type start_op = host_go ? tcs_op_type'(wr_op) : op_cfg;
	wire [1:0] start_panels = start_op[1] ? `TCS_HOST_PANELS :
		(start_op == TCS_TOUCH_XYZ) ? `TCS_XYZ_PANELS : `TCS_XY_PANELS;
	wire two_conv = (cur_op == TCS_TOUCH_XYZ) || (cur_op == TCS_HOST_Z);

	// conversion block length
	wire [3:0] avg_eff = (conv_cfg.average_count == '0) ? `TCS_AVG_NONE :
		conv_cfg.average_count;
	wire [3:0] ratio_eff = (conv_cfg.conv_ratio == '0) ? `TCS_RATIO_UNITY :
		conv_cfg.conv_ratio;
	wire [CNT_W-1:0] res_term = (CNT_W'(conv_cfg.resolution_bits) +
		CNT_W'(`TCS_RES_EXTRA_BIT)) * CNT_W'(ratio_eff);
	wire [CNT_W-1:0] n1 = (ratio_eff == `TCS_RATIO_UNITY) ?
		CNT_W'(`TCS_N1_UNITY) : CNT_W'(`TCS_N1_DIVIDED);
	wire [CNT_W-1:0] block_base = CNT_W'(avg_eff) *
		(res_term + n1 + CNT_W'(`TCS_BLOCK_FIXED)) + CNT_W'(`TCS_BLOCK_TAIL);
	wire [CNT_W-1:0] block_len = block_base +
		(audio_sync ? CNT_W'(AUDIO_EXTRA) : '0) +
		((first_pending && state == TCS_PANEL) ? CNT_W'(FIRST_EXTRA) :
			'0);

	// pen output: high over precharge plus sense of a touch panel phase
	wire pen_next = (state == TCS_PANEL) && !cur_op[1] && touch_sync &&
		(pen_mode != `TCS_PEN_SILENT) &&
		(cnt_rem > CNT_W'(panel_cfg.panel_settle_time));

	// phase sequencing; every phase but idle is a counted run of ticks
	always_comb begin
		next_state = state;
		cnt_load   = 1'b0;
		cnt_value  = '0;
		case (state)
			TCS_IDLE: begin
				if (start) begin
					next_state = TCS_PANEL;
					cnt_load   = 1'b1;
					cnt_value  = panel_len_f(start_op, panel_cfg);
				end
			end
			TCS_PANEL: begin
				if (cnt_zero) begin
					next_state = TCS_CONV;
					cnt_load   = 1'b1;
					cnt_value  = block_len;
				end
			end
			TCS_CONV: begin
				if (cnt_zero) begin
					cnt_load = 1'b1;
					if (conv_extra) begin
						cnt_value = block_len;
					end else if (panels_left != '0) begin
						next_state = TCS_PANEL;
						cnt_value  = panel_len_f(cur_op, panel_cfg);
					end else begin
						next_state = TCS_TAIL;
						cnt_value  = tail_len_f(cur_op, panel_cfg);
					end
				end
			end
			default: begin
				if (cnt_zero) begin
					next_state = TCS_IDLE;
				end
			end
		endcase
	end

	// input synchronisers; the meta stages are never looked at
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			touch_meta <= 1'b0;
			touch_sync <= 1'b0;
			touch_prev <= 1'b0;
			audio_meta <= 1'b0;
			audio_sync <= 1'b0;
		end else begin
			touch_meta <= touch_in;
			touch_sync <= touch_meta;
			touch_prev <= touch_sync;
			audio_meta <= audio_active_in;
			audio_sync <= audio_meta;
		end
	end

	// software settings
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			op_cfg    <= TCS_TOUCH_XY;
			auto_en   <= 1'b0;
			pen_mode  <= '0;
			panel_cfg <= `TCS_RST_PANEL;
			conv_cfg  <= `TCS_RST_CONV;
		end else begin
			if (wr_ctrl) begin
				op_cfg   <= tcs_op_type'(wr_op);
				auto_en  <= bus_in.wdata[`TCS_CTRL_AUTO];
				pen_mode <= bus_in.wdata[`TCS_CTRL_PEN_LSB +: 2];
			end
			if (wr_panel) begin
				panel_cfg <= bus_in.wdata[`TCS_PANEL_W-1:0];
			end
			if (wr_conv) begin
				conv_cfg <= bus_in.wdata[`TCS_CONV_W-1:0];
			end
		end
	end

	// phase bookkeeping
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			state       <= TCS_IDLE;
			cur_op      <= TCS_TOUCH_XY;
			panels_left <= '0;
			conv_extra  <= 1'b0;
		end else begin
			state <= next_state;
			if (start) begin
				cur_op      <= start_op;
				panels_left <= start_panels - 2'h1;
			end else if (state == TCS_PANEL && cnt_zero) begin
				conv_extra <= two_conv && (panels_left == '0);
			end else if (state == TCS_CONV && cnt_zero) begin
				conv_extra <= 1'b0;
				if (!conv_extra && panels_left != '0) begin
					panels_left <= panels_left - 2'h1;
				end
			end
		end
	end

	// first block after a fresh touch; a new touch wins over the clear
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			first_pending <= 1'b0;
		end else if (touch_sync && !touch_prev) begin
			first_pending <= 1'b1;
		end else if (state == TCS_CONV && cnt_zero) begin
			first_pending <= 1'b0;
		end
	end

	// measured duration of the last scan, in oscillator periods
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			dur_count  <= '0;
			last_dur   <= '0;
			scan_count <= '0;
		end else if (start) begin
			dur_count <= '0;
		end else if (state == TCS_TAIL && cnt_zero) begin
			last_dur   <= dur_count;
			scan_count <= scan_count + 8'h01;
		end else if (state != TCS_IDLE && osc_tick) begin
			dur_count <= dur_count + CNT_W'(1);
		end
	end

	// read selection
	always_comb begin
		rd_mux = '0;
		if (bus_in.addr == `TCS_ADDR_CTRL) begin
			rd_mux[`TCS_CTRL_OP_LSB +: 2]  = op_cfg;
			rd_mux[`TCS_CTRL_AUTO]         = auto_en;
			rd_mux[`TCS_CTRL_PEN_LSB +: 2] = pen_mode;
		end else if (bus_in.addr == `TCS_ADDR_PANEL) begin
			rd_mux[`TCS_PANEL_W-1:0] = panel_cfg;
		end else if (bus_in.addr == `TCS_ADDR_CONV) begin
			rd_mux[`TCS_CONV_W-1:0] = conv_cfg;
		end else if (bus_in.addr == `TCS_ADDR_STATUS) begin
			rd_mux[`TCS_ST_BUSY]          = busy_out;
			rd_mux[`TCS_ST_TOUCH]         = touch_sync;
			rd_mux[`TCS_ST_AUDIO]         = audio_sync;
			rd_mux[`TCS_ST_COUNT_LSB +: 8] = scan_count;
		end else if (bus_in.addr == `TCS_ADDR_LAST) begin
			rd_mux[CNT_W-1:0] = last_dur;
		end
	end

	// registered outputs; read data stands only in the cycle after a read
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			rd_data_out        <= '0;
			pen_data_avail_out <= 1'b0;
			busy_out           <= 1'b0;
			done_out           <= 1'b0;
			sample_strobe_out  <= 1'b0;
		end else begin
			rd_data_out        <= bus_in.rd ? rd_mux : '0;
			pen_data_avail_out <= pen_next;
			busy_out           <= (next_state != TCS_IDLE);
			done_out           <= (state == TCS_TAIL) && cnt_zero;
			sample_strobe_out  <= (state == TCS_CONV) && cnt_zero;
		end
	end

	// checking helpers: ticks spent in the current phase and its origin
	logic [CNT_W-1:0] phase_ticks;
	logic             blk_plain;
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			phase_ticks <= '0;
			blk_plain   <= 1'b0;
		end else if (cnt_load) begin
			phase_ticks <= '0;
			blk_plain   <= !audio_sync && !first_pending;
		end else if (osc_tick && !cnt_zero) begin
			phase_ticks <= phase_ticks + CNT_W'(1);
		end
	end
	wire pvs0_chk = (panel_cfg.panel_settle_time == '0);
	wire sns_chk  = (CNT_W'(panel_cfg.sense) != CNT_W'(`TCS_SNS_REF_TICKS));
	wire [CNT_W-1:0] pvs_chk = CNT_W'(panel_cfg.panel_settle_time);

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);

	xy_tail_a: assert property (
		state == TCS_TAIL && cnt_zero && cur_op == TCS_TOUCH_XY |->
		phase_ticks == CNT_W'((pvs0_chk ? `TCS_XY_PVS0_EXTRA : 0) +
			(sns_chk ? `TCS_XY_SNS_EXTRA : 0)))
		else $error("touch xy tail length wrong");
	block_time_a: assert property (
		state == TCS_CONV && cnt_zero && blk_plain |->
		phase_ticks == block_base)
		else $error("conversion block length wrong");
	xyz_tail_a: assert property (
		state == TCS_TAIL && cnt_zero && cur_op == TCS_TOUCH_XYZ |->
		phase_ticks == CNT_W'(`TCS_XYZ_FIXED +
			(pvs0_chk ? `TCS_XYZ_PVS0_EXTRA : 0) +
			(sns_chk ? `TCS_XYZ_SNS_EXTRA : 0)))
		else $error("touch xyz tail length wrong");
	host_tail_a: assert property (
		state == TCS_TAIL && cnt_zero && cur_op == TCS_HOST_XY |->
		phase_ticks == CNT_W'(`TCS_HXY_FIXED +
			(pvs0_chk ? `TCS_HXY_PVS0_EXTRA : 0)))
		else $error("host xy tail length wrong");
	z_tail_a: assert property (
		state == TCS_TAIL && cnt_zero && cur_op == TCS_HOST_Z |->
		phase_ticks == CNT_W'(`TCS_HZ_FIXED +
			(pvs0_chk ? `TCS_HZ_PVS0_EXTRA : 0)))
		else $error("host z tail length wrong");
	audio_stretch_a: assert property (
		state == TCS_PANEL && cnt_zero && audio_sync && !first_pending |=>
		cnt_rem == $past(block_base) + CNT_W'(AUDIO_EXTRA))
		else $error("audio stretch missing");
	first_block_a: assert property (
		state == TCS_PANEL && cnt_zero && first_pending && !audio_sync |=>
		cnt_rem == $past(block_base) + CNT_W'(FIRST_EXTRA))
		else $error("first block extension missing");
	pen_window_a: assert property (
		pen_data_avail_out |-> $past(state) == TCS_PANEL &&
		$past(cnt_rem) > $past(pvs_chk) &&
		$past(pen_mode) != `TCS_PEN_SILENT)
		else $error("pen output outside precharge and sense");
	res_scale_a: assert property (
		$stable(avg_eff) && $stable(ratio_eff) &&
		conv_cfg.resolution_bits == $past(conv_cfg.resolution_bits) + 4'h1
		|-> block_base == $past(block_base) +
			CNT_W'(avg_eff) * CNT_W'(ratio_eff))
		else $error("resolution term does not scale");
	panel_time_a: assert property (
		state == TCS_PANEL && cnt_zero && !cur_op[1] |->
		phase_ticks == CNT_W'(panel_cfg.precharge) +
			CNT_W'(panel_cfg.sense) + pvs_chk)
		else $error("panel interval length wrong");

	xy_done_c: cover property (done_out && cur_op == TCS_TOUCH_XY);
	xyz_done_c: cover property (done_out && cur_op == TCS_TOUCH_XYZ);
	z_done_c: cover property (done_out && cur_op == TCS_HOST_Z);
	pen_pulse_c: cover property ($fell(pen_data_avail_out));
endmodule : tcs_sequencer

/* File: verification/tcs_panel_model.sv */
// far-side model: pen contact through the panel filter, audio power pin
module tcs_panel_model #(
	parameter int SETTLE = 3
) (
	// clock
	input  wire logic clk_in,
	// commands from the bench
	input  wire logic pen_cmd_in,
	input  wire logic audio_cmd_in,
	// pins toward the sequencer
	output logic      touch_out,
	output logic      audio_out
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [SETTLE-1:0] settle_pipe;

	// pins start released so the sequencer never sees an unknown level
	initial begin
		settle_pipe = '0;
		touch_out   = 1'b0;
		audio_out   = 1'b0;
	end

	// filter caps slow the panel, so contact shows a few cycles late
	always @(posedge clk_in) begin
		settle_pipe <= {settle_pipe[SETTLE-2:0], pen_cmd_in};
		touch_out   <= settle_pipe[SETTLE-1];
		audio_out   <= audio_cmd_in;
	end
endmodule : tcs_panel_model

/* File: verification/tcs_sequencer_bench.sv */
// self-checking bench of the touch conversion sequencer
`include "tcs_consts.svh"
module tcs_sequencer_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import tcs_pkg::*;

	localparam int AUDIO_X = 8;
	localparam int FIRST_X = 4;

	// one table row: scan kind, panel delays, converter setup, pen, audio
	typedef struct {
		tcs_op_type op;
		int pre, sns, pvs, avg, bits, ratio, pen;
		bit audio;
	} tcs_row_type;

	logic            clk_in;
	logic            reset_in;
	tcs_bus_req_type bus_in;
	logic [31:0]     rd_data_out;
	logic            touch_in;
	logic            audio_active_in;
	logic            pen_data_avail_out;
	logic            busy_out;
	logic            done_out;
	logic            sample_strobe_out;
	logic            pen_cmd;
	logic            audio_cmd;
	logic [31:0]     rdat;
	int              error_cnt;
	int              check_count;
	int              run_len;
	int              last_run;
	int              strobes;
	int              nblk[4] = '{2, 4, 1, 2};
	logic [3:0]      raddr[5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4};
	logic [31:0]     rval[5] = '{32'h0, 32'h0, 32'h1C1, 32'h0, 32'h0};
	tcs_row_type     rows[9] = '{
		'{TCS_HOST_XY,   0,   0, 0, 1,  0, 1, 0, 0},
		'{TCS_HOST_XY,   7,   9, 3, 2,  3, 2, 0, 0},
		'{TCS_HOST_Z,    0,   0, 0, 1, 11, 1, 0, 0},
		'{TCS_HOST_Z,    0,   0, 5, 0,  0, 0, 0, 0},
		'{TCS_HOST_XY,   0,   0, 2, 1,  0, 1, 0, 1},
		'{TCS_TOUCH_XY,  2, 256, 1, 1,  1, 1, 0, 0},
		'{TCS_TOUCH_XY,  3,   4, 0, 1,  0, 1, 2, 0},
		'{TCS_TOUCH_XYZ, 2,   3, 2, 1,  0, 1, 3, 0},
		'{TCS_TOUCH_XYZ, 1,   2, 0, 1,  0, 1, 1, 0}};

	tcs_sequencer #(.AUDIO_EXTRA(AUDIO_X), .FIRST_EXTRA(FIRST_X),
		.CNT_W(16)) dut (
		.clk_in(clk_in), .reset_in(reset_in), .bus_in(bus_in),
		.rd_data_out(rd_data_out), .touch_in(touch_in),
		.audio_active_in(audio_active_in),
		.pen_data_avail_out(pen_data_avail_out), .busy_out(busy_out),
		.done_out(done_out), .sample_strobe_out(sample_strobe_out));

	tcs_panel_model #(.SETTLE(3)) panel (
		.clk_in(clk_in), .pen_cmd_in(pen_cmd), .audio_cmd_in(audio_cmd),
		.touch_out(touch_in), .audio_out(audio_active_in));

	// 200 MHz clock
	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end

	// pen-high run lengths and block strobes, watched every cycle
	always @(posedge clk_in) begin
		if (sample_strobe_out === 1'b1) begin
			strobes <= strobes + 1;
		end
		if (pen_data_avail_out === 1'b1) begin
			run_len <= run_len + 1;
		end else if (run_len != 0) begin
			last_run <= run_len;
			run_len  <= 0;
		end
	end

	task automatic check(input bit ok, input string what);
		check_count++;
		if (!ok) begin
			error_cnt++;
			$display("mismatch at %0t: %s", $time, what);
		end
	endtask : check

	task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_in);
		bus_in.addr  <= a;
		bus_in.wdata <= d;
		bus_in.wr    <= 1'b1;
		@(posedge clk_in);
		bus_in.wr <= 1'b0;
	endtask : bus_wr

	// read data stands only in the cycle after the strobe
	task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_in);
		bus_in.addr <= a;
		bus_in.rd   <= 1'b1;
		@(posedge clk_in);
		bus_in.rd <= 1'b0;
		#1 d = rd_data_out;
	endtask : bus_rd

	task automatic wait_done(input int limit, output bit seen);
		seen = 1'b0;
		repeat (limit) begin
			@(posedge clk_in);
			#1;
			if (done_out === 1'b1) begin
				seen = 1'b1;
				break;
			end
		end
	endtask : wait_done

	// idle means busy low for 40 cycles in a row
	task automatic wait_idle(input int limit, output bit ok);
		int cnt;
		cnt = 0;
		repeat (limit) begin
			@(posedge clk_in);
			#1 cnt = (busy_out === 1'b0) ? cnt + 1 : 0;
			if (cnt == 40) begin
				break;
			end
		end
		ok = (cnt == 40);
	endtask : wait_idle

	// scan length in ticks; serial command time is not part of it
	function automatic int exp_ticks(input tcs_row_type r);
		int a, q, blk, pan, z, s;
		a   = (r.avg == 0) ? 1 : r.avg;
		q   = (r.ratio == 0) ? 1 : r.ratio;
		blk = a * ((r.bits + 1) * q + ((q == 1) ? 6 : 7) + 12) + 1;
		blk = blk + (r.audio ? AUDIO_X : 0);
		pan = r.pre + r.sns + r.pvs;
		z   = (r.pvs == 0);
		s   = (r.sns != 256);
		case (r.op)
			TCS_TOUCH_XY:  return 2 * pan + 2 * blk + 4 * z + 2 * s;
			TCS_TOUCH_XYZ: return 3 * pan + 4 * blk + 33 + 4 * z + 3 * s;
			TCS_HOST_XY:   return r.pvs + blk + 14 + 2 * z;
			default:       return r.pvs + 2 * blk + 20 + 2 * z;
		endcase
	endfunction : exp_ticks

	// one tick of slack: the tick divider runs free of the scan start
	task automatic check_len(input int want, input string what);
		bus_rd(`TCS_ADDR_LAST, rdat);
		check(rdat[15:0] + 1 >= want && rdat[15:0] <= want + 1,
			$sformatf("%s got %0d want %0d", what, rdat[15:0], want));
	endtask : check_len

	task automatic run_row(input tcs_row_type r);
		bit seen;
		bit touch;
		touch = !r.op[1];
		@(posedge clk_in);
		audio_cmd <= r.audio;
		bus_wr(`TCS_ADDR_PANEL, {2'h0, 10'(r.pvs), 10'(r.sns), 10'(r.pre)});
		bus_wr(`TCS_ADDR_CONV, {20'h0, 4'(r.ratio), 4'(r.bits), 4'(r.avg)});
		bus_rd(`TCS_ADDR_STATUS, rdat);
		check(rdat[2] === r.audio && rdat[1] === 1'b0, "status pins");
		repeat (4) @(posedge clk_in);
		#1 last_run = 0;
		strobes = 0;
		bus_wr(`TCS_ADDR_CTRL, {26'h0, 2'(r.pen), touch, 2'(r.op), !touch});
		if (touch) begin
			pen_cmd <= 1'b1;
			wait_done(40000, seen);
			check_len(exp_ticks(r) + FIRST_X, "first scan");
		end
		wait_done(40000, seen);
		check(seen, "scan never finished");
		check(strobes == nblk[r.op] * (touch ? 2 : 1), "block count");
		if (touch && r.pen != 1) begin
			check(last_run + 26 >= (r.pre + r.sns) * 25 &&
				last_run <= (r.pre + r.sns) * 25 + 26, "pen high time");
		end else if (touch) begin
			check(last_run == 0 && run_len == 0, "pen in silent mode");
		end
		check_len(exp_ticks(r), "scan length");
		@(posedge clk_in);
		pen_cmd <= 1'b0;
		wait_idle(50000, seen);
		check(seen, "stuck busy");
	endtask : run_row

	task automatic tally_and_finish;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : tally_and_finish

	// a hang counts as a mismatch; the tests need about 380 us
	initial begin
		#480000;
		error_cnt++;
		$display("mismatch at %0t: watchdog expired", $time);
		tally_and_finish();
	end

	initial begin
		bit         ok;
		logic [7:0] cnt0;
		reset_in  = 1'b1;
		bus_in    = '0;
		pen_cmd   = 1'b0;
		audio_cmd = 1'b0;
		error_cnt = 0;
		check_count = 0;
		run_len   = 0;
		last_run  = 0;
		strobes   = 0;
		repeat (10) @(posedge clk_in);
		reset_in <= 1'b0;
		foreach (rows[i]) begin
			run_row(rows[i]);
		end
		// back-to-back go: the second lands while busy and is dropped
		bus_rd(`TCS_ADDR_STATUS, rdat);
		cnt0 = rdat[15:8];
		bus_wr(`TCS_ADDR_CTRL, 32'h5);
		#1 check(busy_out === 1'b1, "busy late");
		bus_wr(`TCS_ADDR_CTRL, 32'h5);
		bus_wr(4'hF, 32'hFFFF_FFFF);
		wait_done(4000, ok);
		check(ok, "host scan never finished");
		wait_idle(40, ok);
		check(ok, "go while busy started a scan");
		bus_rd(`TCS_ADDR_STATUS, rdat);
		check(rdat[15:8] === cnt0 + 8'h01 && rdat[0] === 1'b0, "scan count");
		bus_rd(4'hF, rdat);
		check(rdat === 32'h0, "unmapped read");
		// go with a touch kind is ignored
		bus_wr(`TCS_ADDR_CTRL, 32'h1);
		repeat (3) @(posedge clk_in);
		#1 check(busy_out === 1'b0, "touch kind started by go");
		// reset in mid-scan clears outputs and settings
		bus_wr(`TCS_ADDR_CTRL, 32'h7);
		repeat (30) @(posedge clk_in);
		reset_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		reset_in <= 1'b0;
		#1 check(busy_out === 1'b0 && done_out === 1'b0, "outputs in reset");
		foreach (raddr[i]) begin
			bus_rd(raddr[i], rdat);
			check(rdat === rval[i], $sformatf("reset value at %0d", i));
		end
		@(posedge clk_in);
		#1 check(rd_data_out === 32'h0, "read data lingers");
		tally_and_finish();
	end
endmodule : tcs_sequencer_bench
